/* dv/gpa_link_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module gpa_link_partner
  import gpa_pkg::*;
(
  // clock and control
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         go_i,
  input  wire logic [15:0]  word_i,
  input  wire logic [1:0]   gap_i,
  // link
  input  wire gpa_ability_t tx_i,
  output var  gpa_rx_t      rx_o
);
  logic [1:0] wait_q;
  logic [1:0] acked_q;

  // repeat the word, set its ack once the device acks, stop after three acked
  always_ff @(posedge clk_i) begin
    rx_o.valid <= 1'b0;
    rx_o.word  <= ~rx_o.word;
    if (rst_i || !go_i) begin
      wait_q     <= 2'h0;
      acked_q    <= 2'h0;
      rx_o.word  <= word_i;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (acked_q != 2'h3) begin
      rx_o.valid <= 1'b1;
      rx_o.word  <= word_i | {1'b0, tx_i.ack, 14'h0000};
      wait_q     <= gap_i;
      acked_q    <= acked_q + {1'b0, tx_i.ack};
    end
  end
endmodule : gpa_link_partner
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gpa_map.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench
  import gpa_pkg::*;
;
  logic         clk, rst, psel, penable, pwrite, sync, lp_go;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  logic [15:0]  lp_word, w;
  logic [1:0]   lp_gap;
  logic [3:0]   pstrb;
  logic         pready, pslverr, pcs_rst, an_en, link_up;
  gpa_rx_t      rx;
  gpa_ability_t tx_word;
  logic [32:0]  expq[$];
  int           err_total, checks_done, cycles, rst_pulses;

  gpa_autoneg_regs dut_u (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr), .RX_I(rx), .SYNC_I(sync),
    .TX_WORD_O(tx_word), .PCS_RESET_O(pcs_rst), .AN_ENABLE_O(an_en), .LINK_UP_O(link_up));
  gpa_link_partner lp_u (.clk_i(clk), .rst_i(rst), .go_i(lp_go), .word_i(lp_word),
    .gap_i(lp_gap), .tx_i(tx_word), .rx_o(rx));

  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_of_test();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // read results against the oldest note, pulse count, hang limit
  always @(posedge clk) begin
    cycles++;
    if (pcs_rst === 1'b1) rst_pulses++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      `CHK({pslverr, prdata}, expq.pop_front())
    end
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    if (!wr) expq.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, {idx, 2'b00}, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [15:0] e);
    apb(1'b0, {idx, 2'b00}, 32'h0, {17'h0, e});
  endtask : rd

  // let the partner run a full exchange, bounded wait for link up
  task automatic negotiate(input logic [15:0] pw);
    @(posedge clk);
    lp_go   <= 1'b0;
    lp_word <= pw;
    lp_gap  <= 2'($urandom_range(3));
    sync    <= 1'b1;
    @(posedge clk);
    lp_go <= 1'b1;
    for (int n = 0; n < 300 && link_up !== 1'b1; n++) @(posedge clk);
  endtask : negotiate

  // main sequence
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; sync = 1'b0; lp_go = 1'b0; lp_word = 16'h0000; lp_gap = 2'h0;
    pstrb = 4'h3;
    w = 16'($urandom(32'h3a27));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`GPA_IDX_CTRL, 16'h1000);
    rd(`GPA_IDX_STAT, 16'h0008);
    rd(`GPA_IDX_LOCAL, 16'h0020);
    rd(`GPA_IDX_PARTNER, 16'h0000);
    apb(1'b0, 12'h248, 32'h0, {1'b1, 32'h0});
    apb(1'b0, 12'h241, 32'h0, {1'b1, 32'h0});
    wr(`GPA_IDX_STAT, 32'hFFFF);
    wr(`GPA_IDX_PARTNER, 32'hFFFF);
    rd(`GPA_IDX_STAT, 16'h0008);
    rd(`GPA_IDX_PARTNER, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom);
      w[8:7] = 2'(i);
      w[13:12] = 2'(3 - i);
      w[6] = 1'b0;
      wr(`GPA_IDX_LOCAL, {16'($urandom), w});
      rd(`GPA_IDX_LOCAL, w & 16'h31E0);
    end
    // byte lanes: low lane alone, then high lane alone, then control without high lane
    pstrb <= 4'h1;
    wr(`GPA_IDX_LOCAL, 32'hFFBF);
    rd(`GPA_IDX_LOCAL, (w & 16'h3100) | 16'h00A0);
    pstrb <= 4'h2;
    wr(`GPA_IDX_LOCAL, 32'h0000);
    rd(`GPA_IDX_LOCAL, 16'h00A0);
    pstrb <= 4'h1;
    wr(`GPA_IDX_CTRL, 32'h0000);
    rd(`GPA_IDX_CTRL, 16'h1000);
    pstrb <= 4'h3;
    w = 16'($urandom) & 16'hB1E0;
    wr(`GPA_IDX_LOCAL, 32'h01A0);
    negotiate(w);
    `CHK(link_up, 1'b1)
    rd(`GPA_IDX_STAT, 16'h002C);
    rd(`GPA_IDX_LOCAL, 16'h41A0);
    rd(`GPA_IDX_PARTNER, w | 16'h4000);
    `CHK(tx_word, 16'h41A0)
    @(posedge clk);
    sync <= 1'b0;
    rd(`GPA_IDX_STAT, 16'h0008);
    rd(`GPA_IDX_PARTNER, 16'h0000);
    negotiate(w);
    wr(`GPA_IDX_CTRL, 32'h1200);
    rd(`GPA_IDX_CTRL, 16'h1000);
    rd(`GPA_IDX_STAT, 16'h0008);
    rd(`GPA_IDX_PARTNER, 16'h0000);
    negotiate(w);
    wr(`GPA_IDX_CTRL, 32'h9000);
    rd(`GPA_IDX_CTRL, 16'h1000);
    rd(`GPA_IDX_STAT, 16'h0008);
    rd(`GPA_IDX_LOCAL, 16'h01A0);
    `CHK(rst_pulses, 1)
    wr(`GPA_IDX_CTRL, 32'h0);
    @(negedge clk);
    `CHK(an_en, 1'b0)
    rd(`GPA_IDX_CTRL, 16'h0000);
    rd(`GPA_IDX_STAT, 16'h000C);
    // second reset in mid-run, partner held idle, restores the reset values
    @(posedge clk);
    rst   <= 1'b1;
    lp_go <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`GPA_IDX_CTRL, 16'h1000);
    rd(`GPA_IDX_LOCAL, 16'h0020);
    rd(`GPA_IDX_STAT, 16'h0008);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire

/* hdl/gpa_autoneg_regs.sv */
`timescale 1ns/100ps
`include "gpa_map.svh"
`default_nettype none

module gpa_autoneg_regs
  import gpa_pkg::*;
(
  // clock and reset
  input  wire logic         CLK_I,
  input  wire logic         RST_I,
  // apb slave
  input  wire logic         PSEL_I,
  input  wire logic         PENABLE_I,
  input  wire logic         PWRITE_I,
  input  wire logic [11:0]  PADDR_I,
  input  wire logic [31:0]  PWDATA_I,
  input  wire logic [3:0]   PSTRB_I,
  output logic              PREADY_O,
  output logic [31:0]       PRDATA_O,
  output logic              PSLVERR_O,
  // link partner side
  input  wire gpa_rx_t      RX_I,
  input  wire logic         SYNC_I,
  output gpa_ability_t      TX_WORD_O,
  // pcs control
  output logic              PCS_RESET_O,
  output logic              AN_ENABLE_O,
  output logic              LINK_UP_O
);

  // bus decode
  logic [9:0]  addr_idx;
  logic        aligned;
  logic        sel_ctrl;
  logic        sel_stat;
  logic        sel_local;
  logic        sel_part;
  logic        mapped;
  logic        setup;
  logic        wr_en;
  logic [15:0] wmask;

  assign addr_idx  = PADDR_I[11:2];
  assign aligned   = (PADDR_I[1:0] == `GPA_ALIGN_OK);
  assign sel_ctrl  = aligned && (addr_idx == `GPA_IDX_CTRL);
  assign sel_stat  = aligned && (addr_idx == `GPA_IDX_STAT);
  assign sel_local = aligned && (addr_idx == `GPA_IDX_LOCAL);
  assign sel_part  = aligned && (addr_idx == `GPA_IDX_PARTNER);
  assign mapped    = sel_ctrl || sel_stat || sel_local || sel_part;
  assign setup     = PSEL_I && !PENABLE_I;
  assign wr_en     = PSEL_I && PENABLE_I && PWRITE_I && mapped;
  assign wmask     = {{8{PSTRB_I[`GPA_LANE_HI]}}, {8{PSTRB_I[`GPA_LANE_LO]}}};
  // zero wait states: every access phase completes at once
  assign PREADY_O  = 1'h1;

  // control write strobes
  logic ctrl_wr;
  logic restart_pulse;
  logic reset_pulse;

  assign ctrl_wr       = wr_en && sel_ctrl && PSTRB_I[`GPA_LANE_HI];
  assign restart_pulse = ctrl_wr && PWDATA_I[`GPA_CTRL_RESTART];
  assign reset_pulse   = ctrl_wr && PWDATA_I[`GPA_CTRL_RESET];

  // state
  logic          an_en_q;
  logic          soft_rst_q;
  logic [15:0]   local_q;
  logic [15:0]   local_d;
  logic [15:0]   partner_q;
  logic [15:0]   partner_d;
  logic [15:0]   last_q;
  logic [15:0]   last_d;
  logic [1:0]    cnt_q;
  logic [1:0]    cnt_d;
  logic          ack_q;
  logic          ack_d;
  gpa_an_state_t state_q;
  gpa_an_state_t state_d;
  logic          pcs_rst;

  assign pcs_rst = RST_I || soft_rst_q;

  // enable bit, set out of reset
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      an_en_q <= `GPA_AN_EN_RST;
    end else if (ctrl_wr) begin
      an_en_q <= PWDATA_I[`GPA_CTRL_AN_EN];
    end
  end

  // one-cycle reset pulse to the pcs
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      soft_rst_q <= 1'h0;
    end else begin
      soft_rst_q <= reset_pulse;
    end
  end

  // half duplex bit left as software writes it
  assign local_d = (wr_en && sel_local)
                 ? ((local_q & ~(wmask & `GPA_LOCAL_WMASK))
                    | (PWDATA_I[15:0] & wmask & `GPA_LOCAL_WMASK))
                 : local_q;

  // advertisement register, kept across the soft reset
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      local_q <= `GPA_LOCAL_RST;
    end else begin
      local_q <= local_d;
    end
  end

  // received word compare, acknowledge bit ignored
  logic [15:0] rx_cmp;
  logic        rx_match;
  logic [1:0]  cnt_inc;
  logic        rx_take;

  assign rx_cmp   = RX_I.word & ~`GPA_ACK_MASK;
  assign rx_match = (rx_cmp == last_q);
  assign cnt_inc  = (cnt_q == `GPA_MATCH_CNT) ? cnt_q : cnt_q + `GPA_CNT_ONE;
  assign rx_take  = RX_I.valid && SYNC_I;

  // negotiation sequence
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    last_d    = last_q;
    ack_d     = ack_q;
    partner_d = partner_q;
    if (!an_en_q) begin
      state_d = AN_DISABLED;
      cnt_d   = `GPA_CNT_ZERO;
      ack_d   = 1'h0;
    // restart, first enable or lost sync
    end else if (restart_pulse || (state_q == AN_DISABLED) || !SYNC_I) begin
      state_d   = AN_ABILITY;
      cnt_d     = `GPA_CNT_ZERO;
      ack_d     = 1'h0;
      partner_d = `GPA_ZERO16;
    end else if (rx_take) begin
      last_d = rx_cmp;
      cnt_d  = rx_match ? cnt_inc : `GPA_CNT_ONE;
      case (state_q)
        AN_ABILITY: begin
          if (rx_match && (cnt_q == `GPA_CNT_TWO)) begin
            state_d   = AN_ACK;
            ack_d     = 1'h1;
            partner_d = RX_I.word;
            cnt_d     = `GPA_CNT_ZERO;
          end
        end
        AN_ACK: begin
          if (!rx_match) begin
            state_d = AN_ABILITY;
            ack_d   = 1'h0;
            cnt_d   = `GPA_CNT_ONE;
          end else if (!RX_I.word[14]) begin
            cnt_d = cnt_q;
          end else if (cnt_q == `GPA_CNT_TWO) begin
            state_d = AN_COMPLETE;
          end
        end
        AN_COMPLETE: begin
          if (!rx_match) begin
            state_d = AN_ABILITY;
            ack_d   = 1'h0;
            cnt_d   = `GPA_CNT_ONE;
          end
        end
        default: begin
          state_d = AN_ABILITY;
        end
      endcase
    end
  end

  // pcs state cleared by either reset
  always_ff @(posedge CLK_I) begin
    if (pcs_rst) begin
      state_q   <= AN_DISABLED;
      cnt_q     <= `GPA_CNT_ZERO;
      last_q    <= `GPA_ZERO16;
      ack_q     <= 1'h0;
      partner_q <= `GPA_ZERO16;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      last_q    <= last_d;
      ack_q     <= ack_d;
      partner_q <= partner_d;
    end
  end

  // status and readback words
  logic        an_done;
  logic        link_up;
  logic [15:0] stat_word;
  logic [15:0] ctrl_word;
  logic [15:0] local_word;
  logic [15:0] part_word;

  assign an_done   = (state_q == AN_COMPLETE);
  // link valid only with sync and, if enabled, finished negotiation
  assign link_up   = SYNC_I && (!an_en_q || an_done);
  assign stat_word = (`GPA_ZERO16 | (16'(link_up) << `GPA_STAT_LINK))
                   | (16'h1 << `GPA_STAT_AN_ABLE)
                   | (16'(an_done) << `GPA_STAT_AN_DONE);
  // self-clearing bits read as zero
  assign ctrl_word = 16'(an_en_q) << `GPA_CTRL_AN_EN;
  // acknowledge shown, next page forced low in the local word only
  assign local_word = (local_q & `GPA_LOCAL_WMASK) | (ack_q ? `GPA_ACK_MASK : `GPA_ZERO16);
  assign part_word = (partner_q & `GPA_PART_MASK) | (ack_q ? `GPA_ACK_MASK : `GPA_ZERO16);

  // read selection
  logic [15:0] rd_word;
  always_comb begin
    if (sel_ctrl) begin
      rd_word = ctrl_word;
    end else if (sel_stat) begin
      rd_word = stat_word;
    end else if (sel_local) begin
      rd_word = local_word;
    end else if (sel_part) begin
      rd_word = part_word;
    end else begin
      rd_word = `GPA_ZERO16;
    end
  end

  // read-only words have no write path
  // read data and error captured in the setup cycle
  logic [31:0] prdata_q;
  logic        slverr_q;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      prdata_q <= `GPA_ZERO32;
      slverr_q <= 1'h0;
    end else if (setup) begin
      prdata_q <= {16'h0000, rd_word};
      slverr_q <= !mapped;
    end
  end

  // advertised word to the link, registered
  gpa_ability_t tx_q;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      tx_q <= gpa_ability_t'(`GPA_ZERO16);
    end else begin
      tx_q <= gpa_ability_t'(local_word);
    end
  end

  // outputs
  assign PRDATA_O    = prdata_q;
  assign PSLVERR_O   = slverr_q;
  assign TX_WORD_O   = tx_q;
  assign PCS_RESET_O = soft_rst_q;
  assign AN_ENABLE_O = an_en_q;
  assign LINK_UP_O   = link_up;

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  restart_clears_a: assert property (
    restart_pulse && an_en_q && !soft_rst_q |=> state_q == AN_ABILITY && !ack_q && cnt_q == 2'h0)
    else $error("restart did not return to ability phase");

  enable_write_a: assert property (
    ctrl_wr |=> an_en_q == $past(PWDATA_I[`GPA_CTRL_AN_EN]))
    else $error("enable bit not updated by write");

  soft_reset_a: assert property (
    reset_pulse |=> PCS_RESET_O ##1 (!PCS_RESET_O && state_q == AN_DISABLED && !ack_q))
    else $error("soft reset pulse wrong");

  link_needs_sync_a: assert property (
    !SYNC_I |-> !stat_word[`GPA_STAT_LINK] ##1 state_q != AN_COMPLETE)
    else $error("link shown without sync");

  an_able_a: assert property (
    stat_word[`GPA_STAT_AN_ABLE])
    else $error("ability bit not set");

  done_after_ack_a: assert property (
    $rose(an_done) |-> $past(state_q) == AN_ACK && ack_q && $past(cnt_q) == 2'h2)
    else $error("complete without acknowledge phase");

  fd_write_a: assert property (
    wr_en && sel_local && PSTRB_I[0] |=> local_q[5] == $past(PWDATA_I[5]))
    else $error("full duplex field not written");

  ack_three_a: assert property (
    $rose(ack_q) |-> $past(rx_take) && $past(rx_match) && $past(cnt_q) == 2'h2)
    else $error("acknowledge without three matches");

  next_page_zero_a: assert property (
    !TX_WORD_O.more_pages_flag && !local_word[15])
    else $error("next page advertised");

  partner_ack_a: assert property (
    $rose(part_word[14]) |-> $past(rx_take) && partner_q == $past(RX_I.word))
    else $error("partner word not captured with acknowledge");

  ro_write_a: assert property (
    wr_en && (sel_stat || sel_part) |=> $stable(local_q) && $stable(an_en_q))
    else $error("read-only write changed state");

  complete_c: cover property (state_q == AN_ACK ##[1:20] an_done);
  restart_c: cover property (an_done ##1 restart_pulse);
  soft_reset_c: cover property (reset_pulse ##1 PCS_RESET_O);
  unmapped_c: cover property (PSEL_I && PENABLE_I && PSLVERR_O);

endmodule : gpa_autoneg_regs

`default_nettype wire

/* hdl/gpa_map.svh */
`ifndef GPA_MAP_SVH
`define GPA_MAP_SVH
// register indices; the byte address is four times the index
`define GPA_IDX_CTRL      10'h090
`define GPA_IDX_STAT      10'h091
`define GPA_IDX_LOCAL     10'h094
`define GPA_IDX_PARTNER   10'h095
// control and status bit positions
`define GPA_CTRL_RESTART  9
`define GPA_CTRL_AN_EN    12
`define GPA_CTRL_RESET    15
`define GPA_STAT_LINK     2
`define GPA_STAT_AN_ABLE  3
`define GPA_STAT_AN_DONE  5
// byte lane that carries each control bit
`define GPA_LANE_HI       1
`define GPA_LANE_LO       0
// reset values
`define GPA_AN_EN_RST     1'h1
`define GPA_LOCAL_RST     16'h0020
// writable bits of the local ability word (duplex, pause, remote fault)
`define GPA_LOCAL_WMASK   16'h31E0
// bits presented from the received partner word
`define GPA_PART_MASK     16'hB1E0
// acknowledge bit of an ability word
`define GPA_ACK_MASK      16'h4000
// consecutive matching words needed
`define GPA_MATCH_CNT     2'h3
`define GPA_CNT_ONE       2'h1
`define GPA_CNT_ZERO      2'h0
`define GPA_CNT_TWO       2'h2
`define GPA_ZERO16        16'h0000
`define GPA_ZERO32        32'h0000_0000
`define GPA_ALIGN_OK      2'h0
`endif

/* hdl/gpa_pkg.sv */
package gpa_pkg;
  // one ability word as it travels on the link
  typedef struct packed {
    logic       more_pages_flag;
    logic       ack;
    logic [1:0] remote_fault_code;
    logic [2:0] rsvd_hi;
    logic [1:0] pause_ability_field;
    logic       half_duplex_advert;
    logic       full_duplex_advert;
    logic [4:0] rsvd_lo;
  } gpa_ability_t;

  // received word with its strobe
  typedef struct packed {
    logic [15:0] word;
    logic        valid;
  } gpa_rx_t;

  // negotiation progress
  typedef enum logic [1:0] {
    AN_DISABLED,
    AN_ABILITY,
    AN_ACK,
    AN_COMPLETE
  } gpa_an_state_t;
endpackage : gpa_pkg
